//--- hw/tbic_device.sv
`timescale 1ns/1ns
// Framer end: control register on Avalon, link logic on the serial clock
module tbic_device (
    input  wire logic        clk_sys,            // System clock
    input  wire logic        rst,                // Async reset, high
    input  wire logic        clk_en,             // Freezes system-clock state when low; link-clock logic keeps running
    input  wire logic        link_clk,           // Link clock from backplane
    input  wire logic        fast_clk,           // Fast clock for pin 2 output
    input  wire logic [3:0]  avs_address,        // Byte address
    input  wire logic        avs_read,           // Read strobe
    input  wire logic        avs_write,          // Write strobe
    input  wire logic [31:0] avs_writedata,      // Write data
    input  wire logic [3:0]  avs_byteenable,     // Byte enables
    output logic      [31:0] avs_readdata,       // Read data
    output logic             avs_waitrequest,    // Stall
    output logic             sig_bit,            // Sampled signaling bit
    output logic             frac_bit,           // Sampled fractional bit
    output logic             data_bit,           // Sampled serial data
    output logic             data_launch_fall,   // Data launched on falling edge
    tbic_if.device           lnk                 // Backplane link
);
    logic [7:0] ctl_reg;
    logic       fsync_sf_reg;
    logic       rd_done_reg;
    logic [4:0] ts_reg;
    logic [7:0] bit_reg;
    logic [4:0] frm_reg;
    logic       oh_reg;
    logic [2:0] frac_s1_reg, frac_s2_reg;
    logic [3:0] st_s1_reg, st_s2_reg;
    logic [1:0] mode_s1_reg, mode_s2_reg;
    logic       inv_s1_reg, inv_s2_reg;
    logic       sd_rise_reg, sd_fall_reg;
    logic       fsync_in;
    logic       fast_or_mux;
    logic       base_mode;
    logic       sel_hit;
    tbic_pkg::tbic_mode_t mode;

    // Decoded mode seen by system side
    assign mode        = tbic_pkg::decode_mode(ctl_reg[tbic_pkg::BIT_MUX],
                                               ctl_reg[tbic_pkg::BIT_MODE_HI:tbic_pkg::BIT_MODE_LO]);
    assign sel_hit     = (avs_address == tbic_pkg::OFS_CTL) || (avs_address == tbic_pkg::OFS_FSYNC);

    // Reads answer one cycle late, writes at once
    assign avs_waitrequest = avs_read && !rd_done_reg;

    // Control register, byte lane 0
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ctl_reg      <= tbic_pkg::CTL_RESET;
            fsync_sf_reg <= 1'b0;
        end else if (clk_en && avs_write && avs_byteenable[0]) begin
            if (avs_address == tbic_pkg::OFS_CTL) begin
                ctl_reg <= avs_writedata[7:0] & tbic_pkg::CTL_WMASK;
            end
            if (avs_address == tbic_pkg::OFS_FSYNC) begin
                fsync_sf_reg <= avs_writedata[0];
            end
        end
    end

    // Read data; unmapped offsets read zero
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rd_done_reg  <= 1'b0;
            avs_readdata <= 32'h0;
        end else if (clk_en) begin
            rd_done_reg <= avs_read && !rd_done_reg;
            if (avs_read && !rd_done_reg) begin
                case (avs_address)
                    tbic_pkg::OFS_CTL:    avs_readdata <= {24'h0, ctl_reg};
                    tbic_pkg::OFS_FSYNC:  avs_readdata <= {31'h0, fsync_sf_reg};
                    tbic_pkg::OFS_STATUS: avs_readdata <= {24'h0, 1'b0, mode, st_s2_reg};
                    default:              avs_readdata <= 32'h0;
                endcase
            end
        end
    end

    // Configuration into link domain; slow static levels, two flops each
    always_ff @(posedge link_clk or posedge rst) begin
        if (rst) begin
            frac_s1_reg <= 3'h0;
            frac_s2_reg <= 3'h0;
            mode_s1_reg <= 2'h0;
            mode_s2_reg <= 2'h0;
            inv_s1_reg  <= 1'b0;
            inv_s2_reg  <= 1'b0;
        end else begin
            frac_s1_reg <= {fsync_sf_reg, ctl_reg[tbic_pkg::BIT_FRAC], ctl_reg[tbic_pkg::BIT_MUX]};
            frac_s2_reg <= frac_s1_reg;
            mode_s1_reg <= ctl_reg[tbic_pkg::BIT_MODE_HI:tbic_pkg::BIT_MODE_LO];
            mode_s2_reg <= mode_s1_reg;
            inv_s1_reg  <= ctl_reg[tbic_pkg::BIT_INV];
            inv_s2_reg  <= inv_s1_reg;
        end
    end

    // Fast modes or muxed mode override the fractional enable
    assign fast_or_mux = frac_s2_reg[0] || (mode_s2_reg != tbic_pkg::MODE_BASE);
    assign base_mode   = !fast_or_mux;
    // Sync meaning: frame or superframe in fast modes
    assign fsync_in    = lnk.tx_frame_sync;

    // Bit, timeslot and frame counters on the link clock
    always_ff @(posedge link_clk or posedge rst) begin
        if (rst) begin
            bit_reg <= 8'h0;
            ts_reg  <= 5'h0;
            frm_reg <= 5'h0;
            oh_reg  <= 1'b0;
        end else if (fsync_in) begin
            bit_reg <= 8'h0;
            ts_reg  <= 5'h0;
            // Superframe sync in fast modes restarts the multiframe
            if ((fast_or_mux && frac_s2_reg[2]) || (base_mode && lnk.tx_multiframe_sync)) begin
                frm_reg <= 5'h0;
                oh_reg  <= 1'b1;
            end else begin
                frm_reg <= frm_reg + 5'h1;
                oh_reg  <= (frm_reg + 5'h1 == 5'(tbic_pkg::FRAMES_ESF)) ? 1'b1 : 1'b0;
            end
        end else begin
            oh_reg <= 1'b0;
            if (bit_reg == 8'(tbic_pkg::BITS_PER_FRAME - 1)) begin
                bit_reg <= 8'h0;
                ts_reg  <= 5'h0;
                frm_reg <= (frm_reg == 5'(tbic_pkg::FRAMES_ESF - 1)) ? 5'h0 : frm_reg + 5'h1;
                oh_reg  <= (frm_reg == 5'(tbic_pkg::FRAMES_ESF - 1));
            end else begin
                bit_reg <= bit_reg + 8'h1;
                if (bit_reg[2:0] == 3'(tbic_pkg::BITS_PER_TS - 1) && ts_reg != 5'(tbic_pkg::TS_PER_FRAME - 1)) begin
                    ts_reg <= ts_reg + 5'h1;
                end
            end
        end
    end

    // Data sampling on both edges; inversion only at base rate
    always_ff @(posedge link_clk or posedge rst) begin
        if (rst) begin
            sd_rise_reg <= 1'b0;
            sig_bit     <= 1'b0;
            frac_bit    <= 1'b0;
        end else begin
            sd_rise_reg <= lnk.tx_serial_data;
            sig_bit     <= lnk.ts_in[0];
            frac_bit    <= lnk.ts_in[1];
        end
    end
    always_ff @(negedge link_clk or posedge rst) begin
        if (rst) begin
            sd_fall_reg <= 1'b0;
        end else begin
            sd_fall_reg <= lnk.tx_serial_data;
        end
    end
    always_ff @(posedge link_clk or posedge rst) begin
        if (rst) begin
            data_bit         <= 1'b0;
            data_launch_fall <= 1'b0;
        end else begin
            // Partner launching on falling edge is sampled on rising, else on falling
            data_launch_fall <= inv_s2_reg && base_mode;
            data_bit         <= (inv_s2_reg && base_mode) ? sd_rise_reg : sd_fall_reg;
        end
    end

    // Timeslot pins: number out, or fractional/signaling functions
    always_comb begin
        lnk.ts_out  = ts_reg;
        lnk.ts_oe_n = 5'h00;
        if (fast_or_mux) begin
            lnk.ts_oe_n[0] = 1'b1;
        end else if (frac_s2_reg[1]) begin
            lnk.ts_oe_n    = 5'b00011;
            lnk.ts_out[2]  = fast_clk;
            lnk.ts_out[3]  = oh_reg;
            lnk.ts_out[4]  = 1'b0;
        end
    end

    // Status: synchronised inversion, fractional enable and speed back to system clock
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st_s1_reg <= 4'h0;
            st_s2_reg <= 4'h0;
        end else if (clk_en) begin
            st_s1_reg <= {inv_s2_reg, frac_s2_reg[1], mode_s2_reg};
            st_s2_reg <= st_s1_reg;
        end
    end
endmodule : tbic_device

//--- hw/tbic_host.sv
`timescale 1ns/1ns
// Backplane end: makes serial clock, syncs and data
module tbic_host #(
    parameter int DIV = 2                      // Serial clock divider half-period
) (
    input  wire logic        clk_sys,          // System clock
    input  wire logic        rst,              // Async reset, high
    input  wire logic        clk_en,           // Freezes all state when low
    input  wire logic        esf_sel,          // 1: extended superframe
    input  wire logic        data_in,          // Bit to send next
    input  wire logic        sig_in,           // Signaling bit to send
    input  wire logic        frac_in,          // Fractional bit to send
    output logic      [4:0]  ts_seen,          // Timeslot number seen on pins
    tbic_if.host             lnk               // Backplane link
);
    logic [7:0] div_reg;
    logic       sclk_reg;
    logic [7:0] bit_reg;
    logic [4:0] frm_reg;
    logic       fs_reg, ms_reg, sd_reg;
    logic [4:0] ts_s1_reg;

    // Serial clock from divider
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            div_reg  <= 8'h0;
            sclk_reg <= 1'b0;
        end else if (clk_en) begin
            if (div_reg == 8'(DIV - 1)) begin
                div_reg  <= 8'h0;
                sclk_reg <= !sclk_reg;
            end else begin
                div_reg <= div_reg + 8'h1;
            end
        end
    end

    // Frame and superframe syncs, data launched on falling serial edge
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            bit_reg <= 8'h0;
            frm_reg <= 5'h0;
            fs_reg  <= 1'b0;
            ms_reg  <= 1'b0;
            sd_reg  <= 1'b0;
        end else if (clk_en && div_reg == 8'(DIV - 1) && sclk_reg) begin
            sd_reg <= data_in;
            fs_reg <= (bit_reg == 8'(tbic_pkg::BITS_PER_FRAME - 1));
            ms_reg <= (bit_reg == 8'(tbic_pkg::BITS_PER_FRAME - 1)) &&
                      (frm_reg == (esf_sel ? 5'(tbic_pkg::FRAMES_ESF - 1) : 5'(tbic_pkg::FRAMES_SF - 1)));
            if (bit_reg == 8'(tbic_pkg::BITS_PER_FRAME - 1)) begin
                bit_reg <= 8'h0;
                frm_reg <= (fs_reg && ms_reg) ? 5'h0 : frm_reg + 5'h1;
                if (frm_reg == (esf_sel ? 5'(tbic_pkg::FRAMES_ESF - 1) : 5'(tbic_pkg::FRAMES_SF - 1))) begin
                    frm_reg <= 5'h0;
                end
            end else begin
                bit_reg <= bit_reg + 8'h1;
            end
        end
    end

    // Timeslot pins back into host clock, two flops
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ts_s1_reg <= 5'h0;
            ts_seen   <= 5'h0;
        end else if (clk_en) begin
            ts_s1_reg <= lnk.ts_out;
            ts_seen   <= ts_s1_reg;
        end
    end

    assign lnk.tx_serial_clock    = sclk_reg;
    assign lnk.tx_serial_data     = sd_reg;
    assign lnk.tx_frame_sync      = fs_reg;
    assign lnk.tx_multiframe_sync = ms_reg; // base-rate use only here
    // Signaling and fractional bits on repurposed pins
    assign lnk.ts_in = {3'h0, frac_in, sig_in};
endmodule : tbic_host

//--- hw/tbic_if.sv
`timescale 1ns/1ns
// Backplane link between system logic and framer transmit side
interface tbic_if;
    logic       tx_serial_clock;     // Serial clock, driven by backplane
    logic       tx_serial_data;      // Serial data into framer
    logic       tx_frame_sync;       // Frame boundary
    logic       tx_multiframe_sync;  // Superframe sync, used at base rate only
    logic [4:0] ts_out;              // Timeslot pins, framer drive value
    logic [4:0] ts_oe_n;             // Timeslot pins, low while framer drives
    logic [4:0] ts_in;               // Timeslot pins, backplane drive value
    modport device (input tx_serial_clock, tx_serial_data, tx_frame_sync, tx_multiframe_sync, ts_in,
                    output ts_out, ts_oe_n);
    modport host   (output tx_serial_clock, tx_serial_data, tx_frame_sync, tx_multiframe_sync, ts_in,
                    input ts_out, ts_oe_n);
endinterface : tbic_if

//--- hw/tbic_pkg.sv
package tbic_pkg;
    // Control register field positions
    localparam int CTL_W          = 8;
    localparam int BIT_FRAC       = 4;
    localparam int BIT_INV        = 3;
    localparam int BIT_MUX        = 2;
    localparam int BIT_MODE_HI    = 1;
    localparam int BIT_MODE_LO    = 0;
    localparam logic [7:0] CTL_RESET = 8'h00;
    localparam logic [7:0] CTL_WMASK = 8'h1f;
    // Avalon word offsets, byte addressed
    localparam logic [3:0] OFS_CTL    = 4'h0;
    localparam logic [3:0] OFS_STATUS = 4'h4;
    localparam logic [3:0] OFS_FSYNC  = 4'h8;
    // Speed field codes
    localparam logic [1:0] MODE_BASE = 2'h0;
    localparam logic [1:0] MODE_HS2  = 2'h1;
    localparam logic [1:0] MODE_HS4  = 2'h2;
    localparam logic [1:0] MODE_HS8  = 2'h3;
    // Frame structure
    localparam int TS_W            = 5;
    localparam int BITS_PER_TS     = 8;
    localparam int TS_PER_FRAME    = 24;
    localparam int BITS_PER_FRAME  = 193;
    localparam int FRAMES_ESF      = 24;
    localparam int FRAMES_SF       = 12;
    localparam int FRAME_US        = 125;
    localparam int SF_MS_X10       = 15;
    localparam int ESF_MS_X10      = 30;
    localparam int CNT_W           = 8;
    // Decoded interface modes
    typedef enum logic [2:0] {
        tbic_base_t_e, tbic_hs2_e, tbic_hs4_e, tbic_hs8_e, tbic_mux_lo_e, tbic_mux_hi_e
    } tbic_mode_t;
    // Speed field decode depends on muxed enable
    function automatic tbic_mode_t decode_mode(input logic mux, input logic [1:0] sel);
        tbic_mode_t m;
        m = tbic_base_t_e;
        if (mux) begin
            m = sel[BIT_MODE_LO] ? tbic_mux_hi_e : tbic_mux_lo_e;
        end else begin
            case (sel)
                MODE_BASE: m = tbic_base_t_e;
                MODE_HS2:  m = tbic_hs2_e;
                MODE_HS4:  m = tbic_hs4_e;
                default:   m = tbic_hs8_e;
            endcase
        end
        return m;
    endfunction : decode_mode
endpackage : tbic_pkg

//--- test/tb.sv
`timescale 1ns/1ns
module tb;
    logic        clk_sys, rst, fast_clk, avs_read, avs_write, data_in, sig_in, frac_in, base;
    logic [3:0]  avs_address, avs_byteenable;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic        avs_waitrequest, sig_bit, frac_bit, data_bit, data_launch_fall;
    logic [4:0]  ts_seen;
    logic [2:0]  dec;
    logic [7:0]  cfg [8] = '{8'h00, 8'h08, 8'h09, 8'h12, 8'h13, 8'h04, 8'h1d, 8'h10};
    int          errors, n_tests, cycles;
    tbic_if lnk ();
    // Both ends face each other; the host end divides the serial clock from clk_sys
    tbic_device tbic_device_i (.clk_sys(clk_sys), .rst(rst), .clk_en(1'b1), .link_clk(lnk.tx_serial_clock),
        .fast_clk(fast_clk), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .sig_bit(sig_bit), .frac_bit(frac_bit), .data_bit(data_bit),
        .data_launch_fall(data_launch_fall), .lnk(lnk));
    tbic_host #(.DIV(2)) tbic_host_i (.clk_sys(clk_sys), .rst(rst), .clk_en(1'b1), .esf_sel(1'b0),
        .data_in(data_in), .sig_in(sig_in), .frac_in(frac_in), .ts_seen(ts_seen), .lnk(lnk));
    tbic_assertions tbic_assertions_i (.tx_serial_clock(lnk.tx_serial_clock), .rst(rst),
        .tx_frame_sync(lnk.tx_frame_sync), .tx_multiframe_sync(lnk.tx_multiframe_sync),
        .ts_out(lnk.ts_out), .ts_oe_n(lnk.ts_oe_n));
    // System clock, 100 ns
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    // Fast clock, 12 ns, offset so it never lines up with clk_sys
    initial begin
        fast_clk = 1'b0;
        #3;
        forever #6 fast_clk = ~fast_clk;
    end
    task automatic wrap_up();
        $display("errors %0d n_tests %0d", errors, n_tests);
        if (errors == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : wrap_up
    // Hang guard: whole run is under 20000 cycles
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 25000) begin
            errors++;
            $display("[ERR] %0t timeout", $time);
            wrap_up();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // Request held until waitrequest is sampled low at a rising edge; that edge takes it
    task automatic av_write(input logic [3:0] a, input logic [7:0] d, input logic [3:0] be);
        @(posedge clk_sys);
        avs_address <= a;
        avs_writedata <= {24'h0, d};
        avs_byteenable <= be;
        avs_write <= 1'b1;
        do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
        avs_write <= 1'b0;
    endtask : av_write
    task automatic av_read(input logic [3:0] a);
        @(posedge clk_sys);
        avs_address <= a;
        avs_read <= 1'b1;
        do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read <= 1'b0;
    endtask : av_read
    initial begin
        rst = 1'b1;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 4'h0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'h0;
        data_in = 1'b0;
        sig_in = 1'b0;
        frac_in = 1'b0;
        repeat (4) @(posedge clk_sys);
        rst <= 1'b0;
        av_read(tbic_pkg::OFS_CTL);
        chk(rd, 32'h0);
        av_read(tbic_pkg::OFS_STATUS);
        chk(rd, 32'h0);
        // Two writes, one idle cycle apart; the second has no byte lane and must be dropped
        av_write(tbic_pkg::OFS_CTL, 8'hff, 4'hf);
        av_write(tbic_pkg::OFS_CTL, 8'h00, 4'h0);
        av_read(tbic_pkg::OFS_CTL);
        chk(rd, 32'h1f);
        av_write(tbic_pkg::OFS_FSYNC, 8'h01, 4'h1);
        av_read(tbic_pkg::OFS_FSYNC);
        chk(rd, 32'h1);
        av_read(4'hc);
        chk(rd, 32'h0);
        // Every decoded mode, muxed and not; inversion only counts at base rate
        foreach (cfg[i]) begin
            av_write(tbic_pkg::OFS_CTL, cfg[i], 4'h1);
            repeat (16) @(posedge clk_sys);
            base = !cfg[i][2] && cfg[i][1:0] == 2'h0;
            dec = cfg[i][2] ? {2'h2, cfg[i][0]} : {1'b0, cfg[i][1:0]};
            av_read(tbic_pkg::OFS_STATUS);
            chk(rd, {25'h0, dec, cfg[i][3], cfg[i][4], cfg[i][1:0]});
            chk({31'h0, data_launch_fall}, {31'h0, cfg[i][3] && base});
            chk({27'h0, lnk.ts_oe_n}, !base ? 32'h1 : cfg[i][4] ? 32'h3 : 32'h0);
        end
        // Fractional mode is left on; inputs held a full frame so any sampling slot sees them
        for (int v = 0; v < 2; v++) begin
            sig_in <= v[0];
            frac_in <= !v[0];
            data_in <= v[0];
            repeat (800) @(posedge clk_sys);
            chk({31'h0, sig_bit}, {31'h0, v[0]});
            chk({31'h0, frac_bit}, {31'h0, !v[0]});
            chk({31'h0, data_bit}, {31'h0, v[0]});
        end
        // Long base-rate then fractional runs let the link checks see whole frames and the first superframe mark
        av_write(tbic_pkg::OFS_CTL, 8'h00, 4'h1);
        repeat (5000) @(posedge clk_sys);
        chk({31'h0, ts_seen < 5'd24}, 32'h1);
        av_write(tbic_pkg::OFS_CTL, 8'h10, 4'h1);
        repeat (10000) @(posedge clk_sys);
        wrap_up();
    end
endmodule : tb

//--- test/tbic_assertions.sv
`timescale 1ns/1ns
// Link-side checks, clocked by the serial clock the backplane end makes
module tbic_assertions (
    input wire logic       tx_serial_clock,     // Link clock
    input wire logic       rst,                 // Async reset, high
    input wire logic       tx_frame_sync,       // Frame mark
    input wire logic       tx_multiframe_sync,  // Superframe mark
    input wire logic [4:0] ts_out,              // Timeslot drive value
    input wire logic [4:0] ts_oe_n              // Timeslot enables, low drives
);
    default clocking cb @(posedge tx_serial_clock); endclocking
    default disable iff (rst);
    logic [7:0]  f_cnt;
    logic [12:0] m_cnt;
    logic [1:0]  f_seen;
    logic        m_seen;
    // Cycles since the last marks; first marks after reset only align, so they are not judged
    always_ff @(posedge tx_serial_clock or posedge rst) begin
        if (rst) begin
            f_cnt <= 8'h00;
            m_cnt <= 13'h0000;
            f_seen <= 2'h0;
            m_seen <= 1'b0;
        end else begin
            f_cnt <= tx_frame_sync ? 8'h00 : f_cnt + 8'h01;
            m_cnt <= tx_multiframe_sync ? 13'h0000 : m_cnt + 13'h0001;
            if (tx_frame_sync && f_seen != 2'h3) begin
                f_seen <= f_seen + 2'h1;
            end
            if (tx_multiframe_sync) begin
                m_seen <= 1'b1;
            end
        end
    end
    a_frame_spacing: assert property ((tx_frame_sync && f_seen != 2'h0) |-> f_cnt == 8'd192)
        else $error("frame mark spacing not 193 bits");
    a_frame_pulse: assert property (tx_frame_sync |=> !tx_frame_sync)
        else $error("frame mark longer than one bit");
    a_msync_aligned: assert property (tx_multiframe_sync |-> tx_frame_sync)
        else $error("superframe mark off a frame boundary");
    a_msync_spacing: assert property ((tx_multiframe_sync && m_seen) |-> (m_cnt == 13'd2315 || m_cnt == 13'd4631))
        else $error("superframe mark spacing wrong");
    a_ts_range: assert property (ts_oe_n == 5'h00 |-> ts_out < 5'd24)
        else $error("timeslot number above 23");
    a_ts_step: assert property (($changed(ts_out) && ts_oe_n == 5'h00 && $past(ts_oe_n) == 5'h00 && f_seen[1])
        |-> (ts_out == $past(ts_out) + 5'd1 || ts_out == 5'd0))
        else $error("timeslot number skipped");
    a_ts_hold: assert property (($changed(ts_out) && ts_oe_n == 5'h00 && $past(ts_oe_n) == 5'h00 && f_seen[1])
        |=> ($stable(ts_out) || ts_oe_n != 5'h00) [*7])
        else $error("timeslot held under 8 bits");
    a_frac_pins: assert property (ts_oe_n[1] |-> (ts_oe_n[0] && ts_oe_n[3:2] == 2'b00))
        else $error("fractional pin roles inconsistent");
    a_ovh_pulse: assert property ((ts_oe_n[1] && ts_out[3]) |=> (!ts_out[3] || !ts_oe_n[1]))
        else $error("overhead pulse longer than one bit");
    c_frac: cover property (ts_oe_n == 5'h03 && ts_out[3]);
    c_fast: cover property (ts_oe_n == 5'h01);
    c_msync: cover property (tx_multiframe_sync && m_seen);
endmodule : tbic_assertions
